// file: bench/host_model.sv
// bus controller model: sends ascii commands one char a cycle
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk_in,
  output logic char_valid_out,
  output logic [7:0] char_out
);
  initial
  begin
    char_valid_out = 1'b0;
    char_out = 8'h00;
  end

  // letters then decimal digits, no spaces
  task automatic send_cmd(string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge core_clk_in);
      #1;
      char_valid_out = 1'b1;
      char_out = s[i];
    end
    @(posedge core_clk_in);
    #1;
    char_valid_out = 1'b0;
    // released data lines never hold the last char
    char_out = ~char_out;
  endtask
endmodule

// file: bench/rcd_checker.sv
// port-level concurrent checks for the remote command decoder
`timescale 1ns/1ps
module rcd_checker
  import cmd_decoder_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic data_ready_in,
  input wire logic triggered_meas_in,
  input wire logic error_in,
  input wire logic local_in,
  input wire logic power_on_in,
  input wire logic poll_in,
  input wire logic [7:0] status_out,
  input wire logic srq_out,
  input wire logic [7:0] polarity_out,
  input wire logic [4:0] functions_out,
  input wire logic qual_level_valid_out,
  input cmd_decoder_pkg::send_kind_e send_pending_out,
  input wire logic send_valid_out,
  input wire logic gate_reset_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_status_holes: assert property (!status_out[3] && !status_out[7])
    else $error("status byte reserved bit set");
  a_srq_mirror: assert property (srq_out == status_out[ST_SERVICE])
    else $error("service line and status bit differ");
  a_ready_sets: assert property (data_ready_in |=> status_out[0])
    else $error("data ready event not shown");
  a_error_sets: assert property (error_in |=> status_out[ST_ERROR])
    else $error("error event not shown");
  a_local_sets: assert property (local_in |=> status_out[ST_LOCAL])
    else $error("local event not shown");
  a_cause_kept: assert property (status_out[ST_ERROR] && !poll_in
    |=> status_out[ST_ERROR]) else $error("cause bit lost before poll");
  a_srq_cause: assert property ($rose(srq_out) |-> $past(data_ready_in
    || triggered_meas_in || error_in || local_in || power_on_in))
    else $error("service request without status event");
  a_pol_zeros: assert property ((polarity_out & ~POLARITY_VALID_BITS)
    == 8'h00) else $error("fixed zero polarity bit set");
  a_level_gated: assert property (qual_level_valid_out
    == polarity_out[POL_QUAL_EN] && functions_out[FN_QUAL]
    == polarity_out[POL_QUAL_EN]) else $error("qualify coupling broken");
  a_send_flag: assert property (send_valid_out
    == (send_pending_out != SEND_NONE)) else $error("send flag wrong");
  a_gate_single: assert property (gate_reset_out |=> !gate_reset_out)
    else $error("gate reset longer than one cycle");

  cover property ($rose(srq_out));
  cover property (gate_reset_out);
  cover property (send_pending_out == SEND_IDENT);
  cover property (qual_level_valid_out && polarity_out[POL_QUAL_HI]);
endmodule

bind remote_command_decoder rcd_checker rcd_checker_i (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .data_ready_in(data_ready_in), .triggered_meas_in(triggered_meas_in),
  .error_in(error_in), .local_in(local_in), .power_on_in(power_on_in),
  .poll_in(poll_in), .status_out(status_out), .srq_out(srq_out),
  .polarity_out(polarity_out), .functions_out(functions_out),
  .qual_level_valid_out(qual_level_valid_out),
  .send_pending_out(send_pending_out), .send_valid_out(send_valid_out),
  .gate_reset_out(gate_reset_out));

// file: bench/tb.sv
// self-checking bench for the remote command decoder
`timescale 1ns/1ps
module tb;
  import cmd_decoder_pkg::*;
  logic core_clk_in, nrst_in, char_valid, srq_out, qual_valid;
  logic send_valid, gate_reset;
  logic [7:0] char_byte, ev, status_out, polarity_out;
  logic [4:0] functions_out;
  send_kind_e send_kind;
  int errors, checks, cycles, gates;

  host_model host_model_i (.core_clk_in(core_clk_in),
    .char_valid_out(char_valid), .char_out(char_byte));
  remote_command_decoder remote_command_decoder_i (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .char_valid_in(char_valid), .char_in(char_byte),
    .data_ready_in(ev[0]), .triggered_meas_in(ev[1]), .error_in(ev[2]),
    .poll_in(ev[3]), .local_in(ev[4]), .power_on_in(ev[5]),
    .send_done_in(ev[6]), .status_out(status_out), .srq_out(srq_out),
    .polarity_out(polarity_out), .functions_out(functions_out),
    .qual_level_valid_out(qual_valid), .send_pending_out(send_kind),
    .send_valid_out(send_valid), .gate_reset_out(gate_reset));

  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (gate_reset === 1'b1)
      gates++;
    if (cycles == 5000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmd(string s);
    host_model_i.send_cmd(s);
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask

  task automatic pulse(int b);
    ev[b] = 1'b1;
    @(posedge core_clk_in);
    #1;
    ev[b] = 1'b0;
  endtask

  task automatic t_reset;
    chk("polarity", polarity_out, POLARITY_RESET);
    chk("functions", {3'h0, functions_out}, 8'h00);
    chk("status", status_out, 8'h00);
    chk("send", {4'h0, send_kind}, 8'h00);
  endtask

  task automatic t_mask;
    string c[7] = '{"RM7;", "RM0;", "QM16;", "SM32;", "RM64;", "RM255;",
      "RM1000;"};
    int b[7] = '{2, 0, 4, 5, 0, 5, 0};
    logic q[7] = '{1, 0, 1, 1, 0, 1, 0};
    logic [7:0] e;
    for (int i = 0; i < 7; i++)
    begin
      cmd(c[i]);
      pulse(b[i]);
      e = 8'h01 << b[i];
      e[6] = q[i];
      chk(c[i], status_out, e);
      chk("srq", {7'h00, srq_out}, {7'h00, q[i]});
      pulse(3);
      chk("polled", status_out, 8'h00);
    end
  endtask

  task automatic t_pol;
    string c[15] = '{"RP55;", "RP16;", "RP48;", "RP7;", "RP255;", "RP32;",
      "RP23;", "PQ1;", "PC2;", "PT2;", "PP2;", "PQ2;", "PP1;", "PT1;", "PC1;"};
    logic [7:0] p[15] = '{8'h37, 8'h10, 8'h30, 8'h07, 8'h37, 8'h00, 8'h17,
      8'h37, 8'h36, 8'h34, 8'h30, 8'h10, 8'h14, 8'h16, 8'h17};
    for (int i = 0; i < 15; i++)
    begin
      cmd(c[i]);
      chk(c[i], polarity_out, p[i]);
      chk("level", {7'h00, qual_valid}, {7'h00, p[i][4]});
    end
    cmd("SP;");
    chk("readback", {4'h0, send_kind}, {4'h0, SEND_POLARITY});
  endtask

  task automatic t_func;
    string c[18] = '{"FR1;", "FE1;", "FS1;", "FU1;", "F0;", "FU1;", "F1;",
      "FS1;", "FS0;", "FQ0;", "FQ1;", "FR1;", "PS0;", "FU1;", "PS1;", "PT2;",
      "RS;", "ZZ1;"};
    logic [7:0] f[18] = '{8'h11, 8'h13, 8'h17, 8'h1f, 8'h00, 8'h08, 8'h10,
      8'h14, 8'h10, 8'h00, 8'h10, 8'h11, 8'h10, 8'h18, 8'h10, 8'h10, 8'h00,
      8'h00};
    for (int i = 0; i < 18; i++)
    begin
      cmd(c[i]);
      chk(c[i], {3'h0, functions_out}, f[i]);
    end
    chk("edges", polarity_out, 8'h07);
    cmd("PS1;");
    chk("armed", {4'h0, send_kind}, {4'h0, SEND_TRIG_SIG});
    chk("gate pulses", gates[7:0], 8'h03);
  endtask

  task automatic t_send;
    string c[8] = '{"SS1;", "SS2;", "SL1;", "SL2;", "SE;", "SP;", "SI;",
      "ID;"};
    for (int i = 0; i < 8; i++)
    begin
      cmd(c[i]);
      chk(c[i], {4'h0, send_kind}, 8'((i < 7) ? i + 1 : 7));
      chk("valid", {7'h00, send_valid}, 8'h01);
    end
    cmd("FE0;");
    chk("aborted", {4'h0, send_kind}, 8'h00);
    cmd("SS2;");
    pulse(6);
    chk("done", {7'h00, send_valid}, 8'h00);
    cmd("RM2;");
    cmd("ST;");
    pulse(1);
    chk("trigger bit", status_out, 8'h42);
  endtask

  initial
  begin
    nrst_in = 1'b0;
    ev = 8'h00;
    repeat (6) @(posedge core_clk_in);
    #1;
    nrst_in = 1'b1;
    t_reset();
    t_mask();
    t_pol();
    t_func();
    t_send();
    end_sim();
  end
endmodule

// file: include/cmd_bus_if.sv
// decoded command carried from the parser to the executor
`timescale 1ns/1ps
interface cmd_bus_if;
  import cmd_decoder_pkg::*;
  logic valid;
  cmd_decoder_pkg::op_e op;
  logic [2:0] sel;
  logic [7:0] arg;
  cmd_decoder_pkg::send_kind_e send;
  modport parser (output valid, output op, output sel, output arg,
    output send);
  modport executor (input valid, input op, input sel, input arg,
    input send);
endinterface

// file: include/cmd_decoder_pkg.sv
// shared constants and types for the remote command decoder
package cmd_decoder_pkg;
  localparam int unsigned ARG_DIGITS = 3;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] POLARITY_RESET = 8'h07;
  localparam logic [4:0] FUNC_RESET = 5'h00;
  localparam logic [7:0] MASK_ENABLE_BITS = 8'h37;
  localparam logic [7:0] POLARITY_VALID_BITS = 8'h37;
  localparam int unsigned POL_CLOCK = 0;
  localparam int unsigned POL_START = 1;
  localparam int unsigned POL_STOP = 2;
  localparam int unsigned POL_QUAL_EN = 4;
  localparam int unsigned POL_QUAL_HI = 5;
  localparam int unsigned ST_DATA_READY = 0;
  localparam int unsigned ST_TRIGGERED = 1;
  localparam int unsigned ST_ERROR = 2;
  localparam int unsigned ST_LOCAL = 4;
  localparam int unsigned ST_POWER_ON = 5;
  localparam int unsigned ST_SERVICE = 6;
  localparam int unsigned FN_RECALL = 0;
  localparam int unsigned FN_EDIT = 1;
  localparam int unsigned FN_SIG_LATCH = 2;
  localparam int unsigned FN_UNST_LATCH = 3;
  localparam int unsigned FN_QUAL = 4;
  localparam logic [7:0] ASCII_0 = 8'h30;
  localparam logic [7:0] ASCII_9 = 8'h39;
  localparam logic [7:0] ASCII_CR = 8'h0d;
  localparam logic [7:0] ASCII_LF = 8'h0a;

  typedef enum logic [3:0] {
    SEND_NONE = 4'h0,
    SEND_TRIG_SIG = 4'h1,
    SEND_UNST_SIG = 4'h2,
    SEND_PROBE_NOW = 4'h3,
    SEND_PROBE_TRIG = 4'h4,
    SEND_ERROR = 4'h5,
    SEND_POLARITY = 4'h6,
    SEND_IDENT = 4'h7
  } send_kind_e;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_MASK_LOAD = 5'h01,
    OP_POL_LOAD = 5'h02,
    OP_FUNC_SET = 5'h03,
    OP_FUNC_CLR = 5'h04,
    OP_EDGE_RISE = 5'h05,
    OP_EDGE_FALL = 5'h06,
    OP_QUAL_HIGH = 5'h07,
    OP_QUAL_LOW = 5'h08,
    OP_COMPAT_PRESET = 5'h09,
    OP_PROBE_OFF = 5'h0a,
    OP_PROBE_ON = 5'h0b,
    OP_NORMAL_PRESET = 5'h0c,
    OP_QUAL_PRESET = 5'h0d,
    OP_SEND = 5'h0e,
    OP_TRIG_ARM = 5'h0f
  } op_e;
endpackage

// file: src/cmd_parser.sv
// ascii command parser: letters, optional suffix digits, terminator
`timescale 1ns/1ps
module cmd_parser
  import cmd_decoder_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic char_valid_in,
  input wire logic [7:0] char_in,
  cmd_bus_if.parser cmd
);
  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [1:0] nlet;
    logic [1:0] ndig;
    logic [9:0] num;
    logic v;
    op_e op;
    logic [2:0] sel;
    logic [7:0] arg;
    send_kind_e send;
  } state_s;
  state_s st_reg, st_next;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= ASCII_0 && c <= ASCII_9;
  endfunction

  always_comb
  begin
    logic [9:0] n;
    logic [7:0] a;
    n = st_reg.num;
    a = n[7:0];
    st_next = st_reg;
    st_next.v = 1'b0;
    if (char_valid_in)
    begin
      if (is_digit(char_in) && st_reg.nlet == 2'd2)
      begin
        if (st_reg.ndig != 2'(ARG_DIGITS))
        begin
          st_next.num = 10'(n * 10'd10 + 10'(char_in - ASCII_0));
          st_next.ndig = st_reg.ndig + 2'd1;
        end
      end
      else if (!is_digit(char_in) && st_reg.nlet == 2'd2 &&
        (st_reg.ndig != 2'd0 || char_in < 8'h41 || char_in == 8'h3b ||
        st_reg.c0 != 8'h00))
      begin
        // complete command in hand: decode it
        st_next.v = 1'b1;
        st_next.op = OP_NONE;
        st_next.sel = 3'd0;
        st_next.arg = a;
        st_next.send = SEND_NONE;
        case ({st_reg.c0, st_reg.c1})
          16'h524d, 16'h514d, 16'h534d: st_next.op = OP_MASK_LOAD;
          16'h5250: st_next.op = OP_POL_LOAD;
          16'h5253: st_next.op = OP_COMPAT_PRESET;
          16'h5053: st_next.op = (a == 8'h01) ? OP_PROBE_ON : OP_PROBE_OFF;
          16'h4672, 16'h4652, 16'h4645, 16'h4653, 16'h4655, 16'h4651:
          begin
            case (st_reg.c1)
              8'h52: st_next.sel = 3'(FN_RECALL);
              8'h45: st_next.sel = 3'(FN_EDIT);
              8'h53: st_next.sel = 3'(FN_SIG_LATCH);
              8'h55: st_next.sel = 3'(FN_UNST_LATCH);
              default: st_next.sel = 3'(FN_QUAL);
            endcase
            st_next.op = (a == 8'h01) ? OP_FUNC_SET : OP_FUNC_CLR;
          end
          16'h5043, 16'h5054, 16'h5050:
          begin
            case (st_reg.c1)
              8'h43: st_next.sel = 3'(POL_CLOCK);
              8'h54: st_next.sel = 3'(POL_START);
              default: st_next.sel = 3'(POL_STOP);
            endcase
            st_next.op = (a == 8'h02) ? OP_EDGE_FALL : OP_EDGE_RISE;
          end
          16'h5051: st_next.op = (a == 8'h02) ? OP_QUAL_LOW : OP_QUAL_HIGH;
          16'h5354:
          begin
            st_next.op = OP_TRIG_ARM;
          end
          16'h5353:
          begin
            st_next.op = OP_SEND;
            st_next.send = (a == 8'h02) ? SEND_UNST_SIG : SEND_TRIG_SIG;
          end
          16'h534c:
          begin
            st_next.op = OP_SEND;
            st_next.send = (a == 8'h02) ? SEND_PROBE_TRIG : SEND_PROBE_NOW;
          end
          16'h5345:
          begin
            st_next.op = OP_SEND;
            st_next.send = SEND_ERROR;
          end
          16'h5350:
          begin
            st_next.op = OP_SEND;
            st_next.send = SEND_POLARITY;
          end
          16'h5349, 16'h4944:
          begin
            st_next.op = OP_SEND;
            st_next.send = SEND_IDENT;
          end
          default: st_next.op = OP_NONE;
        endcase
        if ({st_reg.c0, st_reg.c1} == 16'h4630)
        begin
          st_next.op = OP_NORMAL_PRESET;
        end
        if ({st_reg.c0, st_reg.c1} == 16'h4631)
        begin
          st_next.op = OP_QUAL_PRESET;
        end
        st_next.nlet = 2'd0;
        st_next.ndig = 2'd0;
        st_next.num = 10'd0;
        if (char_in >= 8'h41)
        begin
          st_next.c0 = char_in;
          st_next.nlet = 2'd1;
        end
      end
      else if (char_in >= 8'h41 && char_in <= 8'h5a)
      begin
        if (st_reg.nlet == 2'd0)
        begin
          st_next.c0 = char_in;
          st_next.nlet = 2'd1;
        end
        else
        begin
          st_next.c1 = char_in;
          st_next.nlet = 2'd2;
        end
      end
      else if (is_digit(char_in) && st_reg.nlet == 2'd1)
      begin
        // short form such as F0/F1: letter then one digit
        st_next.c1 = char_in;
        st_next.nlet = 2'd2;
      end
      else
      begin
        st_next.nlet = 2'd0;
        st_next.ndig = 2'd0;
        st_next.num = 10'd0;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign cmd.valid = st_reg.v;
  assign cmd.op = st_reg.op;
  assign cmd.sel = st_reg.sel;
  assign cmd.arg = st_reg.arg;
  assign cmd.send = st_reg.send;
endmodule

// file: src/remote_command_decoder.sv
// top: executes decoded remote commands on the instrument state
`timescale 1ns/1ps
module remote_command_decoder
  import cmd_decoder_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic char_valid_in,
  input wire logic [7:0] char_in,
  input wire logic data_ready_in,
  input wire logic triggered_meas_in,
  input wire logic error_in,
  input wire logic local_in,
  input wire logic power_on_in,
  input wire logic poll_in,
  input wire logic send_done_in,
  output logic [7:0] status_out,
  output logic srq_out,
  output logic [7:0] polarity_out,
  output logic [4:0] functions_out,
  output logic qual_level_valid_out,
  output cmd_decoder_pkg::send_kind_e send_pending_out,
  output logic send_valid_out,
  output logic gate_reset_out
);
  import cmd_decoder_pkg::*;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] polarity;
    logic [4:0] func;
    send_kind_e send;
    logic trig_armed;
    logic gate_rst;
  } state_s;
  state_s st_reg, st_next;

  cmd_bus_if cmd ();
  logic [7:0] events;
  logic [7:0] levels;

  cmd_parser u_parser (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .char_valid_in(char_valid_in),
    .char_in(char_in),
    .cmd(cmd)
  );

  // the qualify function bit lives in the polarity byte as well
  function automatic logic [7:0] couple_qual(input logic [7:0] p,
    input logic en);
    logic [7:0] r;
    r = p;
    r[POL_QUAL_EN] = en;
    if (!en)
    begin
      r[POL_QUAL_HI] = 1'b0;
    end
    return r & POLARITY_VALID_BITS;
  endfunction

  always_comb
  begin
    st_next = st_reg;
    st_next.gate_rst = 1'b0;
    if (send_done_in)
    begin
      st_next.send = SEND_NONE;
    end
    if (triggered_meas_in)
    begin
      st_next.trig_armed = 1'b0;
    end
    if (cmd.valid && cmd.op != OP_NONE)
    begin
      st_next.send = SEND_NONE;
      case (cmd.op)
        OP_MASK_LOAD: st_next.mask = cmd.arg;
        OP_POL_LOAD:
        begin
          st_next.polarity = couple_qual(cmd.arg, cmd.arg[POL_QUAL_EN]);
          st_next.func[FN_QUAL] = cmd.arg[POL_QUAL_EN];
        end
        OP_FUNC_SET, OP_FUNC_CLR:
        begin
          st_next.func[cmd.sel] = (cmd.op == OP_FUNC_SET);
          if (cmd.sel == 3'(FN_QUAL))
          begin
            st_next.polarity = couple_qual(st_reg.polarity,
              cmd.op == OP_FUNC_SET);
          end
        end
        OP_EDGE_RISE: st_next.polarity[cmd.sel] = 1'b1;
        OP_EDGE_FALL: st_next.polarity[cmd.sel] = 1'b0;
        OP_QUAL_HIGH: st_next.polarity[POL_QUAL_HI] = 1'b1;
        OP_QUAL_LOW: st_next.polarity[POL_QUAL_HI] = 1'b0;
        OP_COMPAT_PRESET:
        begin
          st_next.func = FUNC_RESET;
          st_next.polarity = POLARITY_RESET;
        end
        OP_PROBE_OFF:
        begin
          st_next.func[3:0] = 4'h0;
          st_next.gate_rst = 1'b1;
        end
        OP_PROBE_ON:
        begin
          st_next.func[3:0] = 4'h0;
          st_next.send = SEND_TRIG_SIG;
          st_next.gate_rst = 1'b1;
        end
        OP_NORMAL_PRESET:
        begin
          st_next.func = FUNC_RESET;
          st_next.polarity = couple_qual(st_reg.polarity, 1'b0);
        end
        OP_QUAL_PRESET:
        begin
          st_next.func = FUNC_RESET;
          st_next.func[FN_QUAL] = 1'b1;
          st_next.polarity = couple_qual(st_reg.polarity, 1'b1);
        end
        OP_SEND: st_next.send = cmd.send;
        OP_TRIG_ARM: st_next.trig_armed = 1'b1;
        default: st_next.send = SEND_NONE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      st_reg.mask <= MASK_RESET;
      st_reg.polarity <= POLARITY_RESET;
      st_reg.func <= FUNC_RESET;
      st_reg.send <= SEND_NONE;
      st_reg.trig_armed <= 1'b0;
      st_reg.gate_rst <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  always_comb
  begin
    events = 8'h00;
    events[ST_DATA_READY] = data_ready_in;
    events[ST_TRIGGERED] = triggered_meas_in && st_reg.trig_armed;
    events[ST_ERROR] = error_in;
    events[ST_LOCAL] = local_in;
    events[ST_POWER_ON] = power_on_in;
    levels = 8'h00;
  end

  status_service u_status (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .mask_in(st_reg.mask),
    .events_in(events),
    .levels_in(levels),
    .poll_in(poll_in),
    .status_out(status_out),
    .srq_out(srq_out)
  );

  assign polarity_out = st_reg.polarity;
  assign functions_out = st_reg.func;
  assign qual_level_valid_out = st_reg.polarity[POL_QUAL_EN];
  assign send_pending_out = st_reg.send;
  assign send_valid_out = (st_reg.send != SEND_NONE);
  assign gate_reset_out = st_reg.gate_rst;
endmodule

// file: src/status_service.sv
// status byte and masked service request
`timescale 1ns/1ps
module status_service
  import cmd_decoder_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] mask_in,
  input wire logic [7:0] events_in,
  input wire logic [7:0] levels_in,
  input wire logic poll_in,
  output logic [7:0] status_out,
  output logic srq_out
);
  typedef struct packed {
    logic [7:0] sticky;
    logic service_request_flag;
  } state_s;
  state_s st_reg, st_next;

  always_comb
  begin
    logic [7:0] cur;
    cur = (st_reg.sticky | levels_in) & MASK_ENABLE_BITS;
    st_next = st_reg;
    st_next.sticky = st_reg.sticky;
    // sticky until polled; new event wins over clear
    if (poll_in)
    begin
      st_next.sticky = 8'h00;
    end
    st_next.sticky = (st_next.sticky | events_in) & MASK_ENABLE_BITS;
    if (|(events_in & mask_in & MASK_ENABLE_BITS))
    begin
      st_next.service_request_flag = 1'b1;
    end
    else if (poll_in)
    begin
      st_next.service_request_flag = 1'b0;
    end
    status_out = cur;
    status_out[ST_SERVICE] = st_reg.service_request_flag;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign srq_out = st_reg.service_request_flag;
endmodule
